// ===== verif/csp_clock_ctrl_assertions.sv
// Concurrent checks on the ports of the clock select block.
`timescale 1ns/10ps
module csp_clock_ctrl_assertions
  import csp_pkg::*;
(
  input wire logic sys_clk, // Clock.
  input wire logic sys_rst, // Reset.
  input wire csp_io_s io, // Write port.
  input wire logic sleep_exec, // Sleep strobe.
  input wire logic irq_pending, // Wake request.
  input wire logic watchdog_lock_cond, // Lock condition.
  input wire logic core_clk_en, // Core enable.
  input wire logic irq_enable_set, // Enable set pulse.
  input wire csp_osc_s osc_run, // Oscillator enables.
  input wire logic brownout_level_sel, // Threshold level.
  input wire logic core_sleeping, // Sleep state.
  input wire logic sync_busy // Setting pending.
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  a_sleep_sets_ie: assert property (
    sleep_exec && !core_sleeping |=> irq_enable_set)
    else $error("sleep did not set interrupt enable");
  a_sleep_no_core: assert property (
    core_sleeping |-> !core_clk_en)
    else $error("core clock ran in sleep");
  a_irq_wakes: assert property (
    core_sleeping && irq_pending |=> !core_sleeping)
    else $error("pending interrupt did not wake");
  a_rc1_after_reset: assert property (
    $fell(sys_rst) |-> osc_run.rc1)
    else $error("oscillator one off after reset");
  a_bo_level_write: assert property (
    io.wr && io.addr == IO_ADDR_CLK && !io.aux
    |=> brownout_level_sel == $past(io.data[SC_BOT]))
    else $error("threshold level not written");
  a_cm_write_sync: assert property (
    io.wr && io.addr == IO_ADDR_CLK && io.aux |=> sync_busy)
    else $error("write did not start sync");
  a_xt32_sleep: assert property (
    core_sleeping && !$past(io.wr) |->
    osc_run.xt32 == $past(osc_run.xt32))
    else $error("slow crystal changed in sleep");
  a_bo_runs: assert property (
    (!core_sleeping || !watchdog_lock_cond) |-> osc_run.brownout)
    else $error("brown-out stopped outside stop");
endmodule

// ===== verif/csp_clock_ctrl_tb_top.sv
// Self-checking bench for the clock select and power-down block.
`timescale 1ns/10ps
module csp_clock_ctrl_tb_top;
  import csp_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  csp_io_s io = '0;
  logic sleep_exec = 1'b0;
  logic irq_pending = 1'b0;
  logic watchdog_lock_cond = 1'b0;
  logic ext_fail = 1'b0;
  logic [NUM_PINS-1:0] osc_pin;
  logic core_clk_en, peripheral_clock, irq_enable_set, hw_reset_req;
  logic brownout_level_sel, core_sleeping, sync_busy;
  csp_osc_s osc_run;
  int fail_count = 0;
  int checked = 0;
  int n;
  int codes[$] = '{0, 1, 2, 3};
  logic [3:0] d;

  always #12.5 sys_clk = !sys_clk;

  csp_clock_ctrl #(.XTAL_EDGES(8), .MISS_CYCLES(50)) DUT (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .io(io),
    .sleep_exec(sleep_exec), .irq_pending(irq_pending),
    .watchdog_lock_cond(watchdog_lock_cond), .osc_pin(osc_pin),
    .core_clk_en(core_clk_en), .peripheral_clock(peripheral_clock),
    .irq_enable_set(irq_enable_set), .osc_run(osc_run),
    .brownout_level_sel(brownout_level_sel),
    .hw_reset_req(hw_reset_req), .core_sleeping(core_sleeping),
    .sync_busy(sync_busy));
  csp_osc_model u_osc (.run(osc_run), .ext_fail(ext_fail), .pin(osc_pin));

  function automatic int div_of(int code);
    return code == 0 ? 16 : code == 1 ? 2 : code == 2 ? 4 : 8;
  endfunction

  task automatic check(string name, logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
    end
  endtask

  task automatic cyc(int c);
    repeat (c) @(negedge sys_clk);
  endtask

  // Writes one register, waits for the sync, then leaves a 3-cycle gap.
  task automatic wr(logic aux, logic [3:0] data);
    io = '{1'b1, aux, IO_ADDR_CLK, data};
    cyc(1);
    io.wr = 1'b0;
    n = 0;
    while (sync_busy !== 1'b0 && n < 3000)
    begin
      cyc(1);
      n++;
    end
    check("sync done", n < 3000, 1);
    cyc(3);
  endtask

  // Cycles between two core enable pulses.
  task automatic period(output int c);
    int w;
    for (w = 0; w < 2; w++)
    begin
      c = 0;
      cyc(1);
      while (core_clk_en !== 1'b1 && c < 999)
      begin
        cyc(1);
        c++;
      end
    end
    c++;
  endtask

  task automatic nap(int c);
    sleep_exec = 1'b1;
    cyc(1);
    sleep_exec = 1'b0;
    check("ie set", irq_enable_set, 1);
    check("sleeping", core_sleeping, 1);
    n = 0;
    repeat (c)
    begin
      cyc(1);
      n += (peripheral_clock === 1'b1);
    end
  endtask

  task automatic wake;
    irq_pending = 1'b1;
    cyc(2);
    check("awake", core_sleeping, 0);
    irq_pending = 1'b0;
    cyc(1);
  endtask

  task automatic summarize;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    #1000000;
    fail_count++;
    summarize();
  end

  initial
  begin
    void'($urandom(86));
    cyc(5);
    sys_rst = 1'b0;
    check("level", brownout_level_sel, 1);
    check("runs", osc_run, 6'h25);
    check("busy", sync_busy, 0);
    $display("reset test done");
    repeat (4)
    begin
      d = $urandom;
      wr(1'b0, {d[3], 3'b011});
      check("level", brownout_level_sel, d[3]);
    end
    $display("threshold test done");
    foreach (codes[i])
    begin
      wr(1'b1, {2'b11, codes[i][1:0]});
      period(n);
      check("rc1 div", n == 4 * div_of(codes[i]), 1);
    end
    $display("divider test done");
    wr(1'b0, 4'h1);
    wr(1'b1, 4'h9);
    period(n);
    check("rc2 div", n == 16, 1);
    check("rc1 off", osc_run.rc1, 0);
    check("rc2 on", osc_run.rc2, 1);
    $display("source test done");
    watchdog_lock_cond = 1'b1;
    nap(300);
    check("per kept", n > 0, 1);
    check("bo kept", osc_run.brownout, 1);
    wake();
    irq_pending = 1'b1;
    sleep_exec = 1'b1;
    cyc(1);
    sleep_exec = 1'b0;
    check("ie early", irq_enable_set, 1);
    check("no nap", core_sleeping, 0);
    irq_pending = 1'b0;
    wr(1'b1, 4'h1);
    nap(300);
    check("per halt", n, 0);
    check("rc2 off", osc_run.rc2, 0);
    check("bo off", osc_run.brownout, 0);
    wake();
    $display("sleep test done");
    wr(1'b0, 4'h3);
    ext_fail = 1'b1;
    n = 0;
    while (hw_reset_req !== 1'b1 && n < 200)
    begin
      cyc(1);
      n++;
    end
    check("ext miss", n >= 40 && n <= 60, 1);
    ext_fail = 1'b0;
    $display("supervisor test done");
    wr(1'b0, 4'h2);
    check("xt4 wait", n >= 7 * 10 && n <= 9 * 10, 1);
    period(n);
    check("xt4 div", n, 20);
    check("xt4 on", osc_run.xt4, 1);
    wr(1'b1, 4'h9);
    wr(1'b0, 4'h0);
    check("xt32 wait", n >= 7 * 40 && n <= 9 * 40, 1);
    nap(300);
    check("per 32k", n >= 7 && n <= 8, 1);
    wake();
    wr(1'b1, 4'h1);
    nap(300);
    check("per stop", n, 0);
    check("xt32 kept", osc_run.xt32, 1);
    check("xt4 off", osc_run.xt4, 0);
    check("bo stop", osc_run.brownout, 0);
    wake();
    $display("crystal test done");
    summarize();
  end
endmodule

bind csp_clock_ctrl csp_clock_ctrl_assertions u_chk (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .io(io),
  .sleep_exec(sleep_exec), .irq_pending(irq_pending),
  .watchdog_lock_cond(watchdog_lock_cond), .core_clk_en(core_clk_en),
  .irq_enable_set(irq_enable_set), .osc_run(osc_run),
  .brownout_level_sel(brownout_level_sel),
  .core_sleeping(core_sleeping), .sync_busy(sync_busy));

// ===== verif/csp_osc_model.sv
// Oscillator pins that toggle only while their run enable is high.
`timescale 1ns/10ps
module csp_osc_model
  import csp_pkg::*;
(
  input wire csp_osc_s run, // Run enables from the block.
  input wire logic ext_fail, // Holds the external clock still.
  output logic [NUM_PINS-1:0] pin // Oscillator levels.
);
  initial pin = '0;
  // A stopped oscillator rests low.
  always #50 pin[PIN_RC1] = run.rc1 && !pin[PIN_RC1];
  always #100 pin[PIN_RC2] = run.rc2 && !pin[PIN_RC2];
  always #125 pin[PIN_XT4] = run.xt4 && !pin[PIN_XT4];
  always #75 pin[PIN_EXT] = run.ext && !ext_fail && !pin[PIN_EXT];
  always #500 pin[PIN_XT32] = run.xt32 && !pin[PIN_XT32];
endmodule

// ===== verilog/csp_clock_ctrl.sv
// Clock source selection, core and peripheral clock enables, sleep control.
`timescale 1ns/10ps
//
// Function
// - A clock_mgmt_reg write starts a sync cycle before it applies.
// - Peripheral clock halts in sleep when keep bit is 0, runs when 1.
// - Core select 1 uses RC oscillator 1; 0 uses the picked source.
// - Divider codes 00/11/10/01 divide by 16/8/4/2; reset code is 11.
// - Brown-out level bit 1 picks 1.7 V threshold, 0 picks 2.0 V.
// - Pick 11 ext, 01 RC2, 10 4 MHz, 00 32 kHz; peripheral source/16, 32 kHz undivided.
// - Core select 0 stops RC oscillator 1.
// - A starting crystal passes a 14-stage divider before core use.
// - A selected 32 kHz crystal runs in every power-down state.
// - Sleep sets global interrupt enable and halts the core clock.
// - Interrupts stay possible in sleep; interrupt or reset ends sleep.
// - Sleep holds only while no interrupt is pending or active.
// - Both clocks stopped under watchdog lock stops the picked oscillator unless 32 kHz.
// - Oscillator stop is sleep, keep clear and watchdog lock together.
// - RC oscillator 1 drives the core after power-on reset.
// - Missing external clock for over 1 ms raises a hardware reset while core select is 0.
// - Source or divider changes never yield a short core period.
module csp_clock_ctrl
  import csp_pkg::*;
#(
  parameter int XTAL_EDGES = XTAL_STAB_EDGES,
  parameter int MISS_CYCLES = EXT_MISS_CYCLES
)
(
  input wire logic sys_clk, // System clock, 40 MHz.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire csp_io_s io, // I/O bus write port.
  input wire logic sleep_exec, // Pulse: sleep instruction executed.
  input wire logic irq_pending, // Any interrupt pending or active bit.
  input wire logic watchdog_lock_cond, // Watchdog lock condition.
  input wire logic [NUM_PINS-1:0] osc_pin, // Oscillator output levels.
  output logic core_clk_en, // Core clock enable pulse.
  output logic peripheral_clock, // Peripheral clock enable pulse.
  output logic irq_enable_set, // Pulse: set global interrupt enable.
  output csp_osc_s osc_run, // Oscillator and brown-out enables.
  output logic brownout_level_sel, // 1 selects the low threshold.
  output logic hw_reset_req, // Pulse: external clock failed.
  output logic core_sleeping, // Core is in sleep.
  output logic sync_busy // New clock setting not yet applied.
);

  typedef struct packed
  {
    csp_state_e state;
    logic [3:0] cm;
    logic [3:0] sc;
    logic act_ccs;
    logic [1:0] act_pick;
    logic [1:0] act_css;
    logic sync_pend;
    logic [15:0] stab_cnt;
    logic xtal_ready;
    logic [15:0] miss_cnt;
    logic hw_rst;
    logic irq_en_set;
    logic per32;
  } csp_top_s;

  csp_top_s r;
  csp_top_s next_r;
  logic [NUM_PINS-1:0] edge_p;
  logic cdiv_pulse;
  logic pdiv_pulse;
  logic core_tick;
  logic per_tick;
  logic apply;
  logic cur_ok;
  logic tgt_ok;
  logic osc_stop;
  logic per_run;
  logic sleeping;
  logic [1:0] sc_pick;

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  function automatic logic [4:0] div_ratio(input logic [1:0] css);
    case (css)
      2'b00: div_ratio = DIV_CODE_00;
      2'b01: div_ratio = DIV_CODE_01;
      2'b10: div_ratio = DIV_CODE_10;
      default: div_ratio = DIV_CODE_11;
    endcase
  endfunction

  function automatic logic alt_edge(input logic [1:0] pick,
                                    input logic [NUM_PINS-1:0] e);
    case (pick)
      PICK_EXT: alt_edge = e[PIN_EXT];
      PICK_RC2: alt_edge = e[PIN_RC2];
      PICK_XT4: alt_edge = e[PIN_XT4];
      default: alt_edge = e[PIN_XT32];
    endcase
  endfunction

  function automatic logic is_xtal(input logic [1:0] pick);
    is_xtal = pick == PICK_XT4 || pick == PICK_XT32;
  endfunction

  // ---------------------------------------------------------------
  // Oscillator edge capture
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi = gi + 1)
    begin : g_sync
      csp_edge_sync u_sync
      (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .pin(osc_pin[gi]),
        .rise(edge_p[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // Clock enables and oscillator control
  // ---------------------------------------------------------------
  assign sc_pick = r.sc[SC_PICK_HI:SC_PICK_LO];
  assign sleeping = r.state == ST_SLEEP;
  assign osc_stop = sleeping && !r.cm[CM_KEEP] && watchdog_lock_cond;

  // The running alternative source counts as usable only while it matches the last pick and, for a crystal, is ready.
  assign cur_ok = r.act_ccs || (r.act_pick == sc_pick &&
                  (!is_xtal(sc_pick) || r.xtal_ready));
  assign tgt_ok = r.cm[CM_CCS] || !is_xtal(sc_pick) || r.xtal_ready;

  assign core_tick = !sleeping && (r.act_ccs ? edge_p[PIN_RC1] :
                     (cur_ok && alt_edge(r.act_pick, edge_p)));

  // New settings load once the new source is usable: at the end of a full old period, or at once in sleep or while the old source is not usable.
  assign apply = r.sync_pend && tgt_ok &&
                 (cdiv_pulse || !cur_ok || sleeping);

  csp_div u_core_div
  (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .tick(core_tick),
    .restart(apply),
    .ratio(div_ratio(r.act_css)),
    .pulse(cdiv_pulse)
  );

  // The peripheral divider waits for a crystal to be ready as well.
  assign per_tick = sc_pick != PICK_XT32 &&
                    (!is_xtal(sc_pick) || r.xtal_ready) &&
                    alt_edge(sc_pick, edge_p);

  csp_div u_per_div
  (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .tick(per_tick),
    .restart(1'b0),
    .ratio(PER_DIV),
    .pulse(pdiv_pulse)
  );

  assign per_run = !sleeping || r.cm[CM_KEEP];
  assign peripheral_clock = per_run &&
    (sc_pick == PICK_XT32 ? r.per32 : pdiv_pulse);
  assign core_clk_en = cdiv_pulse && !sleeping;

  // RC oscillator 1 keeps running until a switch away from it is applied,
  // so the core never loses its clock halfway through a switch.
  always_comb
  begin
    osc_run.rc1 = (r.cm[CM_CCS] || r.act_ccs) && !osc_stop;
    osc_run.rc2 = sc_pick == PICK_RC2 && !osc_stop;
    osc_run.xt4 = sc_pick == PICK_XT4 && !osc_stop;
    osc_run.ext = sc_pick == PICK_EXT && !osc_stop;
    osc_run.xt32 = sc_pick == PICK_XT32;
    osc_run.brownout = !osc_stop;
  end

  assign brownout_level_sel = r.sc[SC_BOT];
  assign hw_reset_req = r.hw_rst;
  assign irq_enable_set = r.irq_en_set;
  assign core_sleeping = sleeping;
  assign sync_busy = r.sync_pend;

  // ---------------------------------------------------------------
  // State update
  // ---------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    next_r.hw_rst = 1'b0;
    next_r.irq_en_set = 1'b0;
    next_r.per32 = edge_p[PIN_XT32];

    // ---------------------------------------------------------------
    // Sleep control
    // ---------------------------------------------------------------
    case (r.state)
      ST_RUN:
      begin
        if (sleep_exec)
        begin
          next_r.irq_en_set = 1'b1;
          if (!irq_pending)
            next_r.state = ST_SLEEP;
        end
      end
      ST_SLEEP:
      begin
        if (irq_pending)
          next_r.state = ST_RUN;
      end
      default:
        next_r.state = ST_RUN;
    endcase

    // ---------------------------------------------------------------
    // Synchronisation cycle
    // ---------------------------------------------------------------
    if (apply)
    begin
      next_r.act_ccs = r.cm[CM_CCS];
      next_r.act_css = r.cm[CM_DIV_HI:CM_DIV_LO];
      next_r.act_pick = sc_pick;
      next_r.sync_pend = 1'b0;
    end

    // ---------------------------------------------------------------
    // Register writes
    // ---------------------------------------------------------------
    // A write during apply keeps the cycle pending.
    if (io.wr && io.addr == IO_ADDR_CLK)
    begin
      next_r.sync_pend = 1'b1;
      if (io.aux)
        next_r.cm = io.data;
      else
      begin
        next_r.sc = io.data & SC_WR_MASK;
        if (io.data[SC_PICK_HI:SC_PICK_LO] != sc_pick)
        begin
          next_r.stab_cnt = 16'h0000;
          next_r.xtal_ready = 1'b0;
        end
      end
    end

    // ---------------------------------------------------------------
    // Crystal stabilisation count
    // ---------------------------------------------------------------
    if (!is_xtal(sc_pick) || (sc_pick == PICK_XT4 && osc_stop))
    begin
      next_r.stab_cnt = 16'h0000;
      next_r.xtal_ready = 1'b0;
    end
    else if (!r.xtal_ready && alt_edge(sc_pick, edge_p))
    begin
      if (r.stab_cnt == 16'(XTAL_EDGES - 1))
        next_r.xtal_ready = 1'b1;
      else
        next_r.stab_cnt = r.stab_cnt + 16'h0001;
    end

    // ---------------------------------------------------------------
    // External clock supervisor
    // ---------------------------------------------------------------
    if (sc_pick != PICK_EXT || r.cm[CM_CCS] || osc_stop ||
        edge_p[PIN_EXT])
      next_r.miss_cnt = 16'h0000;
    else if (r.miss_cnt == 16'(MISS_CYCLES - 1))
    begin
      next_r.miss_cnt = 16'h0000;
      next_r.hw_rst = 1'b1;
    end
    else
      next_r.miss_cnt = r.miss_cnt + 16'h0001;

    // ---------------------------------------------------------------
    // Reset state
    // ---------------------------------------------------------------
    // Any reset also ends sleep.
    if (sys_rst)
    begin
      next_r = '0;
      next_r.state = ST_RUN;
      next_r.cm = CM_RESET;
      next_r.sc = SC_RESET;
      next_r.act_ccs = CM_RESET[CM_CCS];
      next_r.act_css = CM_RESET[CM_DIV_HI:CM_DIV_LO];
      next_r.act_pick = SC_RESET[SC_PICK_HI:SC_PICK_LO];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    r <= next_r;
  end

endmodule

// ===== verilog/csp_div.sv
// Programmable tick divider producing a one-cycle enable pulse.
`timescale 1ns/10ps
module csp_div
  import csp_pkg::*;
(
  input wire logic sys_clk, // System clock.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic tick, // Source edge to be counted.
  input wire logic restart, // Starts a fresh period.
  input wire logic [4:0] ratio, // Ticks per output pulse, 2 to 16.
  output logic pulse // One-cycle pulse per full period.
);

  typedef struct packed
  {
    logic [3:0] cnt;
    logic pulse;
  } csp_div_s;

  csp_div_s r;
  csp_div_s next_r;

  always_comb
  begin
    next_r = r;
    next_r.pulse = 1'b0;
    if (restart)
      next_r.cnt = 4'h0;
    else if (tick)
    begin
      if ({1'b0, r.cnt} == ratio - 5'h01)
      begin
        next_r.cnt = 4'h0;
        next_r.pulse = 1'b1;
      end
      else
        next_r.cnt = r.cnt + 4'h1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      r <= '0;
    else
      r <= next_r;
  end

  assign pulse = r.pulse;

endmodule

// ===== verilog/csp_edge_sync.sv
// Three-stage synchroniser that reports rising edges of an oscillator pin.
`timescale 1ns/10ps
module csp_edge_sync
  import csp_pkg::*;
(
  input wire logic sys_clk, // System clock.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic pin, // Asynchronous oscillator level.
  output logic rise // One-cycle pulse per rising edge.
);

  typedef struct packed
  {
    logic [2:0] sh;
    logic stable;
    logic rise;
  } csp_sync_s;

  csp_sync_s r;
  csp_sync_s next_r;

  // A change counts once the second and third stages agree.
  always_comb
  begin
    next_r = r;
    next_r.sh = {r.sh[1:0], pin};
    next_r.rise = 1'b0;
    if (r.sh[2] == r.sh[1] && r.sh[2] != r.stable)
    begin
      next_r.stable = r.sh[2];
      next_r.rise = r.sh[2];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      r <= '0;
    else
      r <= next_r;
  end

  assign rise = r.rise;

endmodule

// ===== verilog/csp_pkg.sv
// Constants and types shared by the clock select and power-down block.
package csp_pkg;

  localparam int SYS_CLK_MHZ = 40;

  // ---------------------------------------------------------------
  // I/O port decode and register layout
  // ---------------------------------------------------------------
  localparam logic [3:0] IO_ADDR_CLK = 4'h3;
  localparam int CM_KEEP = 3;
  localparam int CM_CCS = 2;
  localparam int CM_DIV_HI = 1;
  localparam int CM_DIV_LO = 0;
  localparam logic [3:0] CM_RESET = 4'hF;
  localparam int SC_BOT = 3;
  localparam int SC_PICK_HI = 1;
  localparam int SC_PICK_LO = 0;
  localparam logic [3:0] SC_RESET = 4'hB;
  localparam logic [3:0] SC_WR_MASK = 4'hB;

  // Brown-out thresholds in millivolts, chosen by brownout_level_sel.
  localparam int BO_LOW_MV = 1700;
  localparam int BO_HIGH_MV = 2000;

  // ---------------------------------------------------------------
  // Divider ratios
  // ---------------------------------------------------------------
  localparam logic [4:0] DIV_CODE_00 = 5'h10;
  localparam logic [4:0] DIV_CODE_01 = 5'h02;
  localparam logic [4:0] DIV_CODE_10 = 5'h04;
  localparam logic [4:0] DIV_CODE_11 = 5'h08;
  localparam logic [4:0] PER_DIV = 5'h10;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int XTAL_STAGES = 14;
  localparam int XTAL_STAB_EDGES = 2 ** XTAL_STAGES;
  localparam int EXT_MISS_TIME_US = 1000;
  localparam int EXT_MISS_CYCLES = EXT_MISS_TIME_US * SYS_CLK_MHZ;

  // ---------------------------------------------------------------
  // Oscillator pins and types
  // ---------------------------------------------------------------
  localparam int PIN_RC1 = 0;
  localparam int PIN_RC2 = 1;
  localparam int PIN_XT4 = 2;
  localparam int PIN_EXT = 3;
  localparam int PIN_XT32 = 4;
  localparam int NUM_PINS = 5;

  typedef enum logic [1:0]
  {
    PICK_XT32 = 2'b00,
    PICK_RC2 = 2'b01,
    PICK_XT4 = 2'b10,
    PICK_EXT = 2'b11
  } csp_pick_e;

  typedef enum logic
  {
    ST_RUN = 1'b0,
    ST_SLEEP = 1'b1
  } csp_state_e;

  typedef struct packed
  {
    logic wr;
    logic aux;
    logic [3:0] addr;
    logic [3:0] data;
  } csp_io_s;

  typedef struct packed
  {
    logic rc1;
    logic rc2;
    logic xt4;
    logic ext;
    logic xt32;
    logic brownout;
  } csp_osc_s;

endpackage
